/* hdl/sdi_pkg.sv */
`default_nettype none
package sdi_pkg;
    // ********************************************************
    // Register indices (byte address = index * 4)
    // ********************************************************
    localparam logic [9:0] IDX_SUMMARY  = 10'h080;
    localparam logic [9:0] IDX_RANGE    = 10'h081;
    localparam logic [9:0] IDX_BRIDGE   = 10'h082;
    localparam logic [9:0] IDX_EN0      = 10'h073;
    localparam logic [9:0] IDX_EN1      = 10'h074;
    localparam logic [9:0] IDX_CTRL     = 10'h090;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h091;
    localparam logic [9:0] IDX_IRQ_CLR  = 10'h092;
    localparam logic [9:0] IDX_IRQ_EN   = 10'h093;
    // ********************************************************
    // Summary bit positions
    // ********************************************************
    localparam int B_DONE   = 0;
    localparam int B_FTHR   = 1;
    localparam int B_TLOW   = 4;
    localparam int B_THIGH  = 5;
    localparam int B_PLOW   = 6;
    localparam int B_PHIGH  = 7;
    localparam int B_SENSOR = 8;
    localparam int B_CALC   = 9;
    localparam int B_ADC    = 10;
    localparam int B_CRCREG = 12;
    localparam int B_CRCCOM = 13;
    localparam int B_GEN_EN = 14;
    localparam logic [15:0] STICKY_MASK = 16'h30FF;
    // Range detail field bases, channel added (P=0, T1=1, T2=2)
    localparam int R_CALC_OVF = 0;
    localparam int R_CALC_UDF = 3;
    localparam int R_ADC_OVF  = 6;
    localparam int R_ADC_UDF  = 9;
    // Control register bits
    localparam int C_MODE = 0;
    localparam int C_DIAG = 1;
    // ********************************************************
    // Bridge groups, queue codes, reset values, timing
    // ********************************************************
    localparam logic [15:0] GRP_P  = 16'h03FF;
    localparam logic [15:0] GRP_T1 = 16'h1C00;
    localparam logic [15:0] GRP_T2 = 16'hE000;
    localparam logic [23:0] CODE_BRIDGE = 24'hFFFFF9;
    localparam logic [23:0] CODE_FIRST  = 24'hFFFFF8;
    localparam logic [23:0] DATA_MAX    = 24'hFFFFF7;
    localparam logic [15:0] RST_REG     = 16'h0000;
    localparam int CLOCK_MHZ     = 250;
    localparam int CHECK_TIME_NS = 1000;
    localparam int CHECK_CYCLES  = (CHECK_TIME_NS * CLOCK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {
        SDI_IDLE  = 2'b00,
        SDI_CHECK = 2'b01,
        SDI_CONV  = 2'b11
    } sdi_state_t;
    typedef enum logic [1:0] {
        SDI_P = 2'b00, SDI_T1 = 2'b01, SDI_T2 = 2'b10
    } sdi_kind_t;
endpackage
`default_nettype wire

/* hdl/sdi_top.sv */
// Chosen here: the APB slave port.
`default_nettype none
module sdi_top #(
    parameter int CHECK_CYCLES = sdi_pkg::CHECK_CYCLES
) (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CONV_START,
    input  wire logic [1:0]  CONV_KIND,
    input  wire logic [15:0] SENSOR_CHK,
    output logic             CONV_GO,
    input  wire logic        CONV_END,
    input  wire logic [2:0]  ADC_OVF,
    input  wire logic [2:0]  ADC_UDF,
    input  wire logic [2:0]  CALC_OVF,
    input  wire logic [2:0]  CALC_UDF,
    input  wire logic [3:0]  THRESH,
    input  wire logic [2:0]  FIFO_FLAGS,
    input  wire logic        CRC_COM_ERR,
    input  wire logic        CRC_REG_ERR,
    input  wire logic        DATA_VALID,
    input  wire logic [1:0]  DATA_KIND,
    input  wire logic [23:0] DATA_IN,
    output logic             QUEUE_VALID,
    output logic      [23:0] QUEUE_WORD,
    output logic             ANALOG_OUT_PIN_HIGH,
    output logic             ANALOG_OUT_PIN_LOW,
    output logic             IRQ
);
    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        sdi_pkg::sdi_state_t st;
        logic [11:0] cnt;
        logic [1:0]  kind;
        logic [15:0] chk_hold;
        logic [15:0] bridge;
        logic [11:0] range;
        logic [15:0] sticky;
        logic [15:0] en0;
        logic [15:0] en1;
        logic [1:0]  ctrl;
        logic [15:0] irq_st;
        logic [15:0] irq_en;
        logic [15:0] sum_q;
        logic [31:0] prdata;
        logic        conv_go;
        logic        qvalid;
        logic [23:0] qword;
        logic        hi;
        logic        lo;
    } sdi_regs_t;

    sdi_regs_t q;
    sdi_regs_t next_q;

    logic [15:0] summary;
    logic [9:0]  idx;
    logic        mapped;
    logic        wr;
    logic        c_sensor;
    logic        c_adc;
    logic        c_calc;
    logic        c_crc;
    logic        c_low;
    logic        c_high;
    logic        gen;

    // Bridge check group that one conversion kind owns
    function automatic logic [15:0] grp(input logic [1:0] k);
        case (k)
            sdi_pkg::SDI_T1: grp = sdi_pkg::GRP_T1;
            sdi_pkg::SDI_T2: grp = sdi_pkg::GRP_T2;
            default:         grp = sdi_pkg::GRP_P;
        endcase
    endfunction

    // ********************************************************
    // Decode and combined flags
    // ********************************************************
    assign idx = PADDR[11:2];
    assign wr  = PSEL && PENABLE && PWRITE && mapped;
    always_comb begin
        if (idx == sdi_pkg::IDX_SUMMARY || idx == sdi_pkg::IDX_RANGE) begin
            mapped = 1'b1;
        end else if (idx == sdi_pkg::IDX_BRIDGE || idx == sdi_pkg::IDX_EN0) begin
            mapped = 1'b1;
        end else if (idx == sdi_pkg::IDX_EN1 || idx == sdi_pkg::IDX_CTRL) begin
            mapped = 1'b1;
        end else if (idx == sdi_pkg::IDX_IRQ_STAT || idx == sdi_pkg::IDX_IRQ_CLR) begin
            mapped = 1'b1;
        end else if (idx == sdi_pkg::IDX_IRQ_EN) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Grouped bits summarise the detail registers
    always_comb begin
        summary                 = q.sticky & sdi_pkg::STICKY_MASK;
        summary[sdi_pkg::B_SENSOR] = |q.bridge;
        summary[sdi_pkg::B_CALC]   = |q.range[5:0];
        summary[sdi_pkg::B_ADC]    = |q.range[11:6];
    end

    // Clamp conditions; global enable gates them all
    assign gen      = q.ctrl[sdi_pkg::C_DIAG] && q.en0[sdi_pkg::B_GEN_EN];
    assign c_sensor = q.en0[sdi_pkg::B_SENSOR] && summary[sdi_pkg::B_SENSOR];
    assign c_adc    = q.en0[sdi_pkg::B_ADC] && |(q.range[11:6] & q.en1[11:6]);
    assign c_calc   = q.en0[sdi_pkg::B_CALC] && |(q.range[5:0] & q.en1[5:0]);
    assign c_crc    = q.en0[sdi_pkg::B_CRCREG] && summary[sdi_pkg::B_CRCREG];
    assign c_low    = |(q.en0[7:4] & summary[7:4] & 4'h5);
    assign c_high   = |(q.en0[7:4] & summary[7:4] & 4'hA);

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic [15:0] wclr;
        logic [2:0]  ch;
        logic [11:0] fresh;
        logic [11:0] cmask;
        wclr   = PWDATA[15:0];
        ch     = 3'h0;
        fresh  = 12'h000;
        cmask  = 12'h000;
        next_q = q;
        next_q.conv_go = 1'b0;
        next_q.qvalid  = 1'b0;

        // Check period ahead of each conversion, then hold the result
        case (q.st)
            sdi_pkg::SDI_IDLE: begin
                if (CONV_START) begin
                    next_q.st   = sdi_pkg::SDI_CHECK;
                    next_q.cnt  = 12'(CHECK_CYCLES - 1);
                    next_q.kind = CONV_KIND;
                end
            end
            sdi_pkg::SDI_CHECK: begin
                if (q.cnt == 12'h000) begin
                    next_q.st       = sdi_pkg::SDI_CONV;
                    next_q.chk_hold = SENSOR_CHK;
                    next_q.conv_go  = 1'b1;
                end else begin
                    next_q.cnt = q.cnt - 12'h001;
                end
            end
            sdi_pkg::SDI_CONV: begin
                if (CONV_END) begin
                    next_q.st = sdi_pkg::SDI_IDLE;
                end
            end
            default: begin
                next_q.st = sdi_pkg::SDI_IDLE;
            end
        endcase

        // Software clears detail and summary bits by writing ones
        if (wr && idx == sdi_pkg::IDX_BRIDGE) begin
            next_q.bridge = q.bridge & ~wclr;
        end
        if (wr && idx == sdi_pkg::IDX_RANGE) begin
            next_q.range = q.range & ~wclr[11:0];
        end
        if (wr && idx == sdi_pkg::IDX_SUMMARY) begin
            next_q.sticky = q.sticky & ~wclr;
        end

        // Conversion end folds fresh results into the detail registers;
        // hardware update wins over a clear in the same cycle
        if (q.st == sdi_pkg::SDI_CONV && CONV_END) begin
            ch    = 3'h1 << q.kind;
            fresh = {ADC_UDF & ch, ADC_OVF & ch, CALC_UDF & ch, CALC_OVF & ch};
            cmask = {ch, ch, ch, ch};
            if (!q.ctrl[sdi_pkg::C_MODE]) begin
                next_q.bridge = next_q.bridge | (q.chk_hold & grp(q.kind));
                next_q.range  = next_q.range | fresh;
            end else begin
                next_q.bridge = (next_q.bridge & ~grp(q.kind))
                              | (q.chk_hold & grp(q.kind));
                next_q.range  = (next_q.range & ~cmask) | fresh;
            end
            next_q.sticky[sdi_pkg::B_DONE] = 1'b1;
        end

        // Level events latch into the summary
        next_q.sticky[sdi_pkg::B_PHIGH:sdi_pkg::B_FTHR] =
            next_q.sticky[sdi_pkg::B_PHIGH:sdi_pkg::B_FTHR] | {THRESH, FIFO_FLAGS};
        next_q.sticky[sdi_pkg::B_CRCREG] = next_q.sticky[sdi_pkg::B_CRCREG] | CRC_REG_ERR;
        next_q.sticky[sdi_pkg::B_CRCCOM] = next_q.sticky[sdi_pkg::B_CRCCOM] | CRC_COM_ERR;

        // Enables and control
        if (wr && idx == sdi_pkg::IDX_EN0) begin
            next_q.en0 = PWDATA[15:0];
        end
        if (wr && idx == sdi_pkg::IDX_EN1) begin
            next_q.en1 = PWDATA[15:0];
        end
        if (wr && idx == sdi_pkg::IDX_CTRL) begin
            next_q.ctrl = PWDATA[1:0];
        end
        if (wr && idx == sdi_pkg::IDX_IRQ_EN) begin
            next_q.irq_en = PWDATA[15:0];
        end

        // Interrupt status: rising summary bits, set beats clear
        next_q.sum_q  = summary;
        next_q.irq_st = q.irq_st;
        if (wr && idx == sdi_pkg::IDX_IRQ_CLR) begin
            next_q.irq_st = q.irq_st & ~wclr;
        end
        next_q.irq_st = next_q.irq_st | (summary & ~q.sum_q);

        // Queue words: bridge error code, else keep clear of top codes
        if (DATA_VALID) begin
            next_q.qvalid = 1'b1;
            if ((q.bridge & grp(DATA_KIND)) != sdi_pkg::RST_REG) begin
                next_q.qword = sdi_pkg::CODE_BRIDGE;
            end else if (DATA_IN >= sdi_pkg::CODE_FIRST) begin
                next_q.qword = sdi_pkg::DATA_MAX;
            end else begin
                next_q.qword = DATA_IN;
            end
        end

        // Analog clamp, highest priority first
        next_q.hi = 1'b0;
        next_q.lo = 1'b0;
        if (gen) begin
            if (c_sensor || c_adc || c_crc) begin
                next_q.lo = 1'b1;
            end else if (c_calc) begin
                next_q.hi = 1'b1;
            end else if (c_low) begin
                next_q.lo = 1'b1;
            end else if (c_high) begin
                next_q.hi = 1'b1;
            end
        end

        // Read data captured in the setup cycle
        if (PSEL && !PENABLE) begin
            next_q.prdata = 32'h00000000;
            if (idx == sdi_pkg::IDX_SUMMARY) begin
                next_q.prdata[15:0] = summary;
            end else if (idx == sdi_pkg::IDX_RANGE) begin
                next_q.prdata[11:0] = q.range;
            end else if (idx == sdi_pkg::IDX_BRIDGE) begin
                next_q.prdata[15:0] = q.bridge;
            end else if (idx == sdi_pkg::IDX_EN0) begin
                next_q.prdata[15:0] = q.en0;
            end else if (idx == sdi_pkg::IDX_EN1) begin
                next_q.prdata[15:0] = q.en1;
            end else if (idx == sdi_pkg::IDX_CTRL) begin
                next_q.prdata[1:0] = q.ctrl;
            end else if (idx == sdi_pkg::IDX_IRQ_STAT) begin
                next_q.prdata[15:0] = q.irq_st;
            end else if (idx == sdi_pkg::IDX_IRQ_EN) begin
                next_q.prdata[15:0] = q.irq_en;
            end
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            q <= '0; // diag enable and every enable start at zero
        end else begin
            q <= next_q;
        end
    end

    // Zero wait states: read data was captured in the setup cycle
    assign PREADY              = 1'b1;
    assign PSLVERR             = PSEL && PENABLE && !mapped;
    assign PRDATA              = q.prdata;
    assign CONV_GO             = q.conv_go;
    assign QUEUE_VALID         = q.qvalid;
    assign QUEUE_WORD          = q.qword;
    assign ANALOG_OUT_PIN_HIGH = q.hi;
    assign ANALOG_OUT_PIN_LOW  = q.lo;
    assign IRQ                 = |(q.irq_st & q.irq_en);

    // ********************************************************
    // Assertions
    // ********************************************************
    localparam int A_CHK = CHECK_CYCLES;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    property p_check_len;
        q.st == sdi_pkg::SDI_IDLE && CONV_START |-> !CONV_GO [*2] ##A_CHK CONV_GO;
    endproperty
    a_check_len: assert property (p_check_len) else $error("check period wrong");

    property p_hold;
        q.st != sdi_pkg::SDI_CHECK |=> $stable(q.chk_hold);
    endproperty
    a_hold: assert property (p_hold) else $error("bridge result moved");

    property p_accum;
        q.st == sdi_pkg::SDI_CONV && CONV_END && !q.ctrl[0] && q.kind == 2'h0
        |=> (q.bridge[9:0] & $past(q.chk_hold[9:0])) == $past(q.chk_hold[9:0]);
    endproperty
    a_accum: assert property (p_accum) else $error("mode 0 lost bits");

    property p_overwrite;
        q.st == sdi_pkg::SDI_CONV && CONV_END && q.ctrl[0] && q.kind == 2'h2
        |=> q.bridge[15:13] == $past(q.chk_hold[15:13]);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("mode 1 no overwrite");

    property p_code;
        DATA_VALID && (q.bridge & grp(DATA_KIND)) != 16'h0000
        |=> QUEUE_VALID && QUEUE_WORD == sdi_pkg::CODE_BRIDGE;
    endproperty
    a_code: assert property (p_code) else $error("bridge code missing");

    property p_top_codes;
        QUEUE_VALID |-> QUEUE_WORD < sdi_pkg::CODE_FIRST
                        || QUEUE_WORD == sdi_pkg::CODE_BRIDGE;
    endproperty
    a_top_codes: assert property (p_top_codes) else $error("reserved code leaked");

    property p_diag_off;
        !q.ctrl[sdi_pkg::C_DIAG] |=> !ANALOG_OUT_PIN_HIGH && !ANALOG_OUT_PIN_LOW;
    endproperty
    a_diag_off: assert property (p_diag_off) else $error("clamp while disabled");

    property p_bridge_clamp;
        gen && c_sensor |=> ANALOG_OUT_PIN_LOW && !ANALOG_OUT_PIN_HIGH;
    endproperty
    a_bridge_clamp: assert property (p_bridge_clamp) else $error("bridge clamp");

    property p_irq;
        (q.irq_st & q.irq_en) != 16'h0000 |-> IRQ ##1 (IRQ || $past(wr));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt dropped");
endmodule
`default_nettype wire

/* sim/sdi_sensor_model.sv */
`default_nettype none
// ********************************************************
// Sensor front end: check period, conversion and range flags
// ********************************************************
module sdi_sensor_model #(
    parameter int END_DELAY = 3
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        conv_start,
    input  wire logic        conv_go,
    input  wire logic [15:0] chk_cfg,
    input  wire logic [11:0] flag_cfg,
    output logic      [15:0] sensor_chk,
    output logic             conv_end,
    output logic      [2:0]  adc_ovf,
    output logic      [2:0]  adc_udf,
    output logic      [2:0]  calc_ovf,
    output logic      [2:0]  calc_udf
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       checking;
    logic [3:0] cnt;
    // Check period runs from start until the go pulse, then a short conversion
    always_ff @(posedge clk) begin
        if (rst) begin
            checking <= 1'b0;
            cnt      <= 4'h0;
        end else begin
            if (conv_start && !checking && cnt == 4'h0) begin
                checking <= 1'b1;
            end
            if (conv_go) begin
                checking <= 1'b0;
                cnt      <= END_DELAY[3:0];
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
    assign conv_end = (cnt == 4'h1);
    // Outside their valid cycles the lines show the inverse, so a late sample is caught
    assign sensor_chk = checking ? chk_cfg : ~chk_cfg;
    assign {adc_udf, adc_ovf, calc_udf, calc_ovf} = conv_end ? flag_cfg : ~flag_cfg;
endmodule
`default_nettype wire

/* sim/sdi_top_tb_top.sv */
`default_nettype none
module sdi_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CC = 4;
    logic        clk, rst, psel, pen, pwr, cstart, dvalid, crc_c, crc_r;
    logic        pready, pslverr, go, cend, qvalid, ahigh, alow, irq;
    logic [11:0] paddr, flag_cfg;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  ckind, dkind;
    logic [23:0] din, qword;
    logic [3:0]  thresh;
    logic [2:0]  fifo, aovf, audf, covf, cudf;
    logic [15:0] chk_cfg, schk;
    logic        e;
    int          fail_count, checks_done;
    sdi_top #(.CHECK_CYCLES(CC)) DUT (
        .CLOCK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CONV_START(cstart), .CONV_KIND(ckind), .SENSOR_CHK(schk),
        .CONV_GO(go), .CONV_END(cend), .ADC_OVF(aovf), .ADC_UDF(audf),
        .CALC_OVF(covf), .CALC_UDF(cudf), .THRESH(thresh), .FIFO_FLAGS(fifo),
        .CRC_COM_ERR(crc_c), .CRC_REG_ERR(crc_r), .DATA_VALID(dvalid),
        .DATA_KIND(dkind), .DATA_IN(din), .QUEUE_VALID(qvalid), .QUEUE_WORD(qword),
        .ANALOG_OUT_PIN_HIGH(ahigh), .ANALOG_OUT_PIN_LOW(alow), .IRQ(irq));
    sdi_sensor_model #(.END_DELAY(3)) u_sensor (
        .clk(clk), .rst(rst), .conv_start(cstart), .conv_go(go), .chk_cfg(chk_cfg),
        .flag_cfg(flag_cfg), .sensor_chk(schk), .conv_end(cend), .adc_ovf(aovf),
        .adc_udf(audf), .calc_ovf(covf), .calc_udf(cudf));
    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // No cycle count is assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic rdc(input string name, input logic [9:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0000_0000);
        check(name, r, exp);
    endtask
    // Settled look at the outputs a few cycles after the last change
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic conv(input logic [1:0] k, input logic [15:0] chk, input logic [11:0] fl);
        int n;
        @(posedge clk);
        ckind    <= k;
        chk_cfg  <= chk;
        flag_cfg <= fl;
        cstart   <= 1'b1;
        @(posedge clk);
        cstart <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (go !== 1'b1 && n < 2000);
        // Go shows just after the CC-th edge, so others first sample it at edge CC+1
        check("go delay", n, CC);
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cend !== 1'b1 && n < 2000);
        check("end seen", cend, 1'b1);
        repeat (2) @(posedge clk);
    endtask
    task automatic queue(input logic [1:0] k, input logic [23:0] d, input logic [23:0] exp);
        @(posedge clk);
        dvalid <= 1'b1;
        dkind  <= k;
        din    <= d;
        @(posedge clk);
        dvalid <= 1'b0;
        #1;
        check("queue valid", qvalid, 1'b1);
        check("queue word", qword, exp);
    endtask
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic s_reset;
        rdc("summary", sdi_pkg::IDX_SUMMARY, 32'h0000_0000);
        rdc("bridge", sdi_pkg::IDX_BRIDGE, 32'h0000_0000);
        rdc("range", sdi_pkg::IDX_RANGE, 32'h0000_0000);
        rdc("ctrl", sdi_pkg::IDX_CTRL, 32'h0000_0000);
        xfer(1'b0, 10'h0FF, 32'h0000_0000);
        check("unmapped err", e, 1'b1);
        check("unmapped data", r, 32'h0000_0000);
        check("clamp idle", {ahigh, alow, irq}, 3'b000);
    endtask
    // Mode 0: P and T1 each OR only their own group, and nothing is lost
    task automatic s_accumulate;
        conv(sdi_pkg::SDI_P, 16'h0005, 12'h000);
        conv(sdi_pkg::SDI_P, 16'h0002, 12'h000);
        rdc("bridge or", sdi_pkg::IDX_BRIDGE, 32'h0000_0007);
        conv(sdi_pkg::SDI_T1, 16'hFFFF, 12'h000);
        rdc("bridge t1", sdi_pkg::IDX_BRIDGE, 32'h0000_1C07);
        rdc("summary", sdi_pkg::IDX_SUMMARY, 32'h0000_0101);
    endtask
    task automatic s_queue;
        queue(sdi_pkg::SDI_P, 24'h000010, 24'hFFFFF9);
        queue(sdi_pkg::SDI_T2, 24'hFFFFFF, 24'hFFFFF7);
        queue(sdi_pkg::SDI_T2, 24'hFFFFF8, 24'hFFFFF7);
        queue(sdi_pkg::SDI_T2, 24'h000123, 24'h000123);
    endtask
    task automatic s_mode1;
        xfer(1'b1, sdi_pkg::IDX_CTRL, 32'h0000_0001);
        conv(sdi_pkg::SDI_P, 16'h0000, 12'h000);
        rdc("bridge recover", sdi_pkg::IDX_BRIDGE, 32'h0000_1C00);
        conv(sdi_pkg::SDI_T2, 16'h2000, 12'h100);
        rdc("bridge t2", sdi_pkg::IDX_BRIDGE, 32'h0000_3C00);
        rdc("range adc t2", sdi_pkg::IDX_RANGE, 32'h0000_0100);
        xfer(1'b1, sdi_pkg::IDX_CTRL, 32'h0000_0000);
        conv(sdi_pkg::SDI_P, 16'h0000, 12'h001);
        rdc("range calc p", sdi_pkg::IDX_RANGE, 32'h0000_0101);
    endtask
    // Level conditions latch, then clear by writing ones; derived bits remain
    task automatic s_summary;
        @(posedge clk);
        thresh <= 4'hF;
        fifo   <= 3'h7;
        crc_c  <= 1'b1;
        crc_r  <= 1'b1;
        repeat (2) @(posedge clk);
        {thresh, fifo, crc_c, crc_r} <= 9'h000;
        rdc("summary all", sdi_pkg::IDX_SUMMARY, 32'h0000_37FF);
        xfer(1'b1, sdi_pkg::IDX_SUMMARY, 32'h0000_30FF);
        rdc("summary w1c", sdi_pkg::IDX_SUMMARY, 32'h0000_0700);
    endtask
    task automatic s_clamp;
        xfer(1'b1, sdi_pkg::IDX_EN1, 32'h0000_FFFF);
        xfer(1'b1, sdi_pkg::IDX_EN0, 32'h0000_4700);
        settle;
        check("clamp diag off", {ahigh, alow}, 2'b00);
        xfer(1'b1, sdi_pkg::IDX_CTRL, 32'h0000_0002);
        settle;
        check("clamp bridge", {ahigh, alow}, 2'b01);
        xfer(1'b1, sdi_pkg::IDX_BRIDGE, 32'h0000_FFFF);
        settle;
        check("clamp adc", {ahigh, alow}, 2'b01);
        xfer(1'b1, sdi_pkg::IDX_RANGE, 32'h0000_0100);
        settle;
        check("clamp calc", {ahigh, alow}, 2'b10);
        xfer(1'b1, sdi_pkg::IDX_EN1, 32'h0000_0000);
        settle;
        check("clamp no indiv", {ahigh, alow}, 2'b00);
        xfer(1'b1, sdi_pkg::IDX_EN1, 32'h0000_FFFF);
        // Global enable stays on so only the missing calc enable can hold the pin off
        xfer(1'b1, sdi_pkg::IDX_EN0, 32'h0000_4500);
        settle;
        check("clamp no enable", {ahigh, alow}, 2'b00);
        // Thresholds rank last; a low limit outranks a high one
        xfer(1'b1, sdi_pkg::IDX_EN0, 32'h0000_40F0);
        @(posedge clk);
        thresh <= 4'h2;
        settle;
        check("clamp thr high", {ahigh, alow}, 2'b10);
        @(posedge clk);
        thresh <= 4'h1;
        settle;
        check("clamp thr low", {ahigh, alow}, 2'b01);
        @(posedge clk);
        thresh <= 4'h0;
    endtask
    task automatic s_irq;
        xfer(1'b0, sdi_pkg::IDX_IRQ_STAT, 32'h0000_0000);
        check("irq stat done", r[0], 1'b1);
        #1;
        check("irq masked", irq, 1'b0);
        xfer(1'b1, sdi_pkg::IDX_IRQ_EN, 32'h0000_0001);
        settle;
        check("irq on", irq, 1'b1);
        xfer(1'b1, sdi_pkg::IDX_IRQ_CLR, 32'h0000_0001);
        settle;
        check("irq cleared", irq, 1'b0);
    endtask
    // ********************************************************
    // Clock, watchdog and main sequence
    // ********************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run is about two hundred cycles; this bound is far above it
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
    initial begin
        fail_count = 0;
        checks_done = 0;
        {rst, psel, pen, pwr, cstart, dvalid, crc_c, crc_r} = 8'h80;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        {ckind, dkind, din, thresh, fifo} = 35'h0;
        chk_cfg = 16'h0000;
        flag_cfg = 12'h000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        s_reset();
        s_accumulate();
        s_queue();
        s_mode1();
        s_summary();
        s_clamp();
        s_irq();
        conclude();
    end
endmodule
`default_nettype wire
